// ==== design/dac_channel.sv ====
// one conversion channel with its timing counter and held output
`timescale 1ns/10ps
`include "dac_ctrl_cfg.svh"
module dac_channel
   import dac_ctrl_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic conv_en_i,
   input wire logic out_en_i,
   input wire logic code_write_i,
   input wire code_t code_i,
   input wire logic [15:0] conv_cycles_i,
   output logic [7:0] level_o,
   output logic drive_o,
   output logic valid_o
);
   chan_state_e state_reg, state_next;
   logic [15:0] count_reg, count_next;
   code_t level_reg, level_next;
   logic en_d_reg;

   wire start_w = (conv_en_i && !en_d_reg) || (conv_en_i && code_write_i);
   wire done_w = (count_reg <= 16'h0001);
   // one cycle is spent entering convert, so load one less to keep the limit
   wire [15:0] load_w = conv_cycles_i - 16'h0001;

   // conversion sequencing: restart on enable rise or code write
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      level_next = level_reg;
      if (!conv_en_i) begin
         state_next = CH_IDLE;
      end else if (start_w) begin
         state_next = CH_CONVERT;
         count_next = load_w;
      end else begin
         unique case (state_reg)
            CH_IDLE: begin
               state_next = CH_CONVERT;
               count_next = load_w;
            end
            CH_CONVERT: begin
               if (done_w) begin
                  state_next = CH_HOLD;
                  level_next = code_i;
               end else begin
                  count_next = count_reg - 16'h0001;
               end
            end
            CH_HOLD: begin
               state_next = CH_HOLD;
            end
            default: begin
               state_next = CH_IDLE;
            end
         endcase
      end
   end

   // state registers
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_reg <= CH_IDLE;
         count_reg <= 16'h0000;
         level_reg <= `CODE_RESET;
         en_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         level_reg <= level_next;
         en_d_reg <= conv_en_i;
      end
   end

   // output drive gated by this channel's own enable and its finished conversion (valid_o)
   assign valid_o = (state_reg == CH_HOLD);
   assign drive_o = out_en_i && valid_o;
   assign level_o = level_reg;
endmodule

// ==== design/dac_ctrl.sv ====
// top: wishbone register file and two converter channels
`timescale 1ns/10ps
`include "dac_ctrl_cfg.svh"
module dac_ctrl
   import dac_ctrl_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic standby_i,
   output logic [7:0] chan2_analog_out_o,
   output logic chan2_drive_o,
   output logic chan2_valid_o,
   output logic [7:0] chan3_analog_out_o,
   output logic chan3_drive_o,
   output logic chan3_valid_o
);
   localparam logic [15:0] CONV_CYCLES = 16'(`CONV_CYCLES);

   code_t chan2_code_reg, chan3_code_reg;
   logic chan3_output_enable, chan2_output_enable;
   logic joint_conversion_enable;
   logic stop_reg;
   logic ack_reg, err_reg;
   logic [31:0] rdata_reg;
   logic [2:0] sby_sync_reg;
   logic standby_reg;
   logic chan2_conv_en, chan3_conv_en;
   logic wr2_reg, wr3_reg;

   // bus request decode
   wire req_w = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
   wire sel_lo_w = wb_sel_i[0];
   wire hit2_w = (wb_adr_i == `ADDR_CHAN2_CODE);
   wire hit3_w = (wb_adr_i == `ADDR_CHAN3_CODE);
   wire hitc_w = (wb_adr_i == `ADDR_OUT_CTRL);
   wire hits_w = (wb_adr_i == `ADDR_STOP_CTRL);
   wire mapped_w = hit2_w || hit3_w || hitc_w || hits_w;
   // stopped block only acks its stop register; other addresses get err
   wire open_w = hits_w || !stop_reg;
   wire good_w = req_w && mapped_w && open_w;
   wire bad_w = req_w && !(mapped_w && open_w);
   wire wr_w = good_w && wb_we_i && sel_lo_w;
   wire [7:0] ctrl_rd_w = {chan3_output_enable, chan2_output_enable,
      joint_conversion_enable, `CTRL_RESERVED_ONES};

   // read data selection
   wire [31:0] rd_w = hit2_w ? {24'h000000, chan2_code_reg} :
      hit3_w ? {24'h000000, chan3_code_reg} :
      hitc_w ? {24'h000000, ctrl_rd_w} :
      {31'h00000000, stop_reg};

   // bus answer: one wait cycle, then ack or err for one cycle
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= good_w;
         err_reg <= bad_w;
         rdata_reg <= good_w ? rd_w : 32'h00000000;
      end
   end
   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdata_reg;

   // register writes, taken in the cycle the request is accepted
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         chan2_code_reg <= `CODE_RESET;
         chan3_code_reg <= `CODE_RESET;
         chan3_output_enable <= 1'b0;
         chan2_output_enable <= 1'b0;
         joint_conversion_enable <= 1'b0;
         stop_reg <= `STOP_RESET;
         wr2_reg <= 1'b0;
         wr3_reg <= 1'b0;
      end else begin
         wr2_reg <= wr_w && hit2_w;
         wr3_reg <= wr_w && hit3_w;
         if (wr_w && hit2_w) begin
            chan2_code_reg <= wb_dat_i[7:0];
         end
         if (wr_w && hit3_w) begin
            chan3_code_reg <= wb_dat_i[7:0];
         end
         if (wr_w && hitc_w) begin
            chan3_output_enable <= wb_dat_i[`BIT_CHAN3_OE];
            chan2_output_enable <= wb_dat_i[`BIT_CHAN2_OE];
            joint_conversion_enable <= wb_dat_i[`BIT_JOINT];
         end
         if (wr_w && hits_w) begin
            stop_reg <= wb_dat_i[0];
         end
      end
   end

   // standby pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sby_sync_reg <= 3'b000;
         standby_reg <= 1'b0;
      end else begin
         sby_sync_reg <= {sby_sync_reg[1:0], standby_i};
         if (sby_sync_reg[2] == sby_sync_reg[1]) begin
            standby_reg <= sby_sync_reg[2];
         end
      end
   end

   // conversion enables; standby leaves them and the held level alone
   always_comb begin
      if (joint_conversion_enable) begin
         chan2_conv_en = chan2_output_enable || chan3_output_enable;
         chan3_conv_en = chan2_output_enable || chan3_output_enable;
      end else begin
         chan2_conv_en = chan2_output_enable;
         chan3_conv_en = chan3_output_enable;
      end
      if (stop_reg) begin
         chan2_conv_en = 1'b0;
         chan3_conv_en = 1'b0;
      end
   end

   // channel 2
   dac_channel chan2_unit (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .conv_en_i(chan2_conv_en),
      .out_en_i(chan2_output_enable),
      .code_write_i(wr2_reg),
      .code_i(chan2_code_reg),
      .conv_cycles_i(CONV_CYCLES),
      .level_o(chan2_analog_out_o),
      .drive_o(chan2_drive_o),
      .valid_o(chan2_valid_o)
   );

   // channel 3
   dac_channel chan3_unit (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .conv_en_i(chan3_conv_en),
      .out_en_i(chan3_output_enable),
      .code_write_i(wr3_reg),
      .code_i(chan3_code_reg),
      .conv_cycles_i(CONV_CYCLES),
      .level_o(chan3_analog_out_o),
      .drive_o(chan3_drive_o),
      .valid_o(chan3_valid_o)
   );

   // standby is observed only; held outputs continue unchanged
   wire unused_w = standby_reg;
endmodule

// ==== design/dac_ctrl_cfg.svh ====
// constants for the two-channel converter control block
`ifndef DAC_CTRL_CFG_SVH
`define DAC_CTRL_CFG_SVH

`define ADDR_CHAN2_CODE 4'h0
`define ADDR_CHAN3_CODE 4'h4
`define ADDR_OUT_CTRL 4'h8
`define ADDR_STOP_CTRL 4'hc

`define BIT_CHAN3_OE 7
`define BIT_CHAN2_OE 6
`define BIT_JOINT 5
`define CTRL_RESERVED_ONES 5'h1f
`define CODE_RESET 8'h00
`define STOP_RESET 1'b1

`define CLK_HZ 40000000
`define CONV_TIME_NS 10000
`define CONV_CYCLES ((`CONV_TIME_NS * (`CLK_HZ / 1000000)) / 1000)

`endif

// ==== design/dac_ctrl_pkg.sv ====
// types shared by the converter control files
package dac_ctrl_pkg;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_CONVERT = 2'b01,
      CH_HOLD = 2'b10
   } chan_state_e;
   typedef logic [7:0] code_t;
endpackage

// ==== sim/dac_ctrl_assertions.sv ====
// bus and output checks on the converter control ports
`timescale 1ns/10ps
module dac_ctrl_assertions (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic chan2_drive_o,
   input wire logic chan2_valid_o,
   input wire logic chan3_drive_o,
   input wire logic chan3_valid_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // bus answers
   a_answer_next: assert property (wb_cyc_i && wb_stb_i &&
      !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
      else $error("no answer");
   a_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=>
      !wb_ack_o && !wb_err_o) else $error("answer without request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
      else $error("err too long");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   // output drive needs a finished conversion
   a_drive2_valid: assert property (
      chan2_drive_o |-> chan2_valid_o) else $error("chan2 driven early");
   a_drive3_valid: assert property (
      chan3_drive_o |-> chan3_valid_o) else $error("chan3 driven early");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n_i |=> !wb_ack_o && !chan2_drive_o && !chan3_valid_o)
      else $error("busy after reset");
   c_drive2: cover property (chan2_drive_o);
   c_joint3: cover property (chan3_valid_o && !chan3_drive_o);
   c_err: cover property (wb_err_o);
endmodule
bind dac_ctrl dac_ctrl_assertions i_chk (
   .clock_i(clock_i),
   .rst_n_i(rst_n_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o),
   .chan2_drive_o(chan2_drive_o),
   .chan2_valid_o(chan2_valid_o),
   .chan3_drive_o(chan3_drive_o),
   .chan3_valid_o(chan3_valid_o)
);

// ==== sim/dac_load.sv ====
// load model seen at one analog output pin
`timescale 1ns/10ps
module dac_load (
   input wire logic clock_i,
   input wire logic [7:0] level_i,
   input wire logic drive_i,
   output logic [7:0] seen_o
);
   // driven pin shows code/256 of ref; floating pin wanders
   always_ff @(posedge clock_i) begin
      seen_o <= drive_i ? level_i : ~seen_o;
   end
endmodule

// ==== sim/test_dac_ctrl.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
`include "dac_ctrl_cfg.svh"
module test_dac_ctrl;
   import dac_ctrl_pkg::*;
   logic clock_i = 0, rst_n_i = 0, we = 0, cyc = 0, stb = 0, sb = 0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, err, d2, v2, d3, v3;
   logic [7:0] a2, a3, s2, q;
   logic e;
   int n_errors = 0, checks_done = 0, n;
   always #12.5 clock_i = ~clock_i;
   dac_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err),
      .standby_i(sb), .chan2_analog_out_o(a2), .chan2_drive_o(d2),
      .chan2_valid_o(v2), .chan3_analog_out_o(a3), .chan3_drive_o(d3),
      .chan3_valid_o(v3));
   dac_load i_load (.clock_i(clock_i), .level_i(a2), .drive_i(d2),
      .seen_o(s2));
   task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, x, g);
      end
   endtask
   // one classic cycle, held until ack or err
   task wb(input logic [3:0] a, input logic w, input logic [7:0] d);
      @(posedge clock_i);
      adr <= a; we <= w; wdat <= {24'h0, d}; cyc <= 1; stb <= 1;
      do begin
         @(posedge clock_i);
      end while (ack !== 1'b1 && err !== 1'b1);
      q = rdat[7:0];
      e = err;
      cyc <= 0; stb <= 0;
   endtask
   task wv(input logic ch);
      logic in_time;
      n = 0;
      while ((ch ? v3 : v2) !== 1'b1 && n < 1000) begin
         @(posedge clock_i);
         n++;
      end
      in_time = n <= `CONV_CYCLES && n >= `CONV_CYCLES - 4;
      chk("conv_time", 8'h1, {7'h0, in_time});
   endtask
   task t_stop;
      wb(4'h8, 0, 8'h0); chk("stopped_err", 8'h1, {7'h0, e});
      wb(4'hc, 1, 8'h0);
      wb(4'h8, 0, 8'h0); chk("ctrl_reset", 8'h1f, q);
      wb(4'h2, 0, 8'h0); chk("unmapped", 8'h1, {7'h0, e});
      $display("t_stop done");
   endtask
   task t_regs;
      wb(4'h0, 1, 8'ha5); wb(4'h4, 1, 8'h5a);
      wb(4'h0, 0, 8'h0); chk("code2", 8'ha5, q);
      wb(4'h4, 0, 8'h0); chk("code3", 8'h5a, q);
      wb(4'h8, 1, 8'he0);
      wb(4'h8, 0, 8'h0); chk("ctrl_rw", 8'hff, q);
      wb(4'h8, 1, 8'h00);
      wb(4'h8, 0, 8'h0); chk("ctrl_res", 8'h1f, q);
      sel <= 4'he; wb(4'h0, 1, 8'h11); sel <= 4'hf;
      wb(4'h0, 0, 8'h0); chk("sel_low", 8'ha5, q);
      $display("t_regs done");
   endtask
   task t_conv;
      wb(4'h0, 1, 8'h3c); wb(4'h8, 1, 8'h40);
      wv(0);
      @(posedge clock_i); @(posedge clock_i);
      chk("level", 8'h3c, s2);
      chk("ch3_off", 8'h0, {7'h0, v3});
      wb(4'h0, 1, 8'hc3); @(posedge clock_i);
      chk("restart", 8'h0, {7'h0, v2});
      wv(0);
      sb <= 1; repeat (30) @(posedge clock_i);
      chk("standby", 8'hc3, s2);
      sb <= 0;
      wb(4'h8, 1, 8'h00); @(posedge clock_i);
      chk("disable", 8'h0, {7'h0, d2});
      $display("t_conv done");
   endtask
   task t_joint;
      wb(4'h8, 1, 8'h60);
      wv(1);
      chk("joint_drive3", 8'h0, {7'h0, d3});
      wb(4'h8, 1, 8'h00);
      wb(4'h8, 1, 8'h80);
      wv(1);
      chk("drive3", 8'h1, {7'h0, d3});
      chk("level3", 8'h5a, a3);
      wb(4'h8, 1, 8'h00);
      $display("t_joint done");
   endtask
   task complete_run;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1;
      t_stop; t_regs; t_conv; t_joint;
      complete_run;
   end
   // guard against a hung handshake or conversion
   initial begin
      #200us;
      n_errors++;
      complete_run;
   end
endmodule
